/* bit_and_flag_instruction_exec.sv */
// Execute stage for bit, rotate, flag and control instructions
//
// Overview of operation
// - I/O bit set writes one chosen bit high, others kept, two cycles.
// - I/O bit clear writes one chosen bit low, others kept, two cycles.
// - Rotate left through carry, updates Z C N V, one cycle.
// - Rotate right through carry, updates Z C N V, one cycle.
// - Bit store copies register bit into T flag, one cycle.
// - Bit load copies T flag into register bit, one cycle, flags kept.
// - Sign flag set and clear, one cycle, only that flag.
// - Overflow set, one cycle, only that flag.
// - Overflow clear, one cycle, only that flag.
// - Half-carry set and clear, one cycle, only that flag.
// - Sleep takes one cycle, keeps flags, pulses sleep request.
// - Watchdog restart takes one cycle, keeps flags, pulses restart.
`timescale 1ns/1ps
`default_nettype none
`include "bit_flag_exec_cfg.svh"
module bit_and_flag_instruction_exec (
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic       issueValid,
  input  wire logic [3:0] opCode,
  input  wire logic [2:0] bitSel,
  input  wire logic [5:0] ioAddr,
  input  wire logic [7:0] ioReadData,
  input  wire logic [7:0] regReadData,
  output logic            issueReady,
  output logic      [5:0] ioWriteAddr,
  output logic      [7:0] ioWriteData,
  output logic            ioWriteEn,
  output logic      [5:0] ioReadAddr,
  output logic      [7:0] regWriteData,
  output logic            regWriteEn,
  output logic      [7:0] flagsOut,
  output logic            sleepReq,
  output logic            watchdogRestart,
  output logic            instrDone
);
  bit_flag_exec_pkg::op_t    op;
  bit_flag_exec_pkg::state_t state_reg;
  bit_flag_exec_pkg::state_t state_next;
  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  logic [2:0] ioBit_reg;
  logic       take;
  logic       sleepTake;
  logic [7:0] rotResult;
  logic       rotC;
  logic       rotZ;
  logic       rotN;
  logic       rotV;

  function automatic logic [7:0] bitMask(input logic [2:0] pos);
    bitMask = 8'h01 << pos;
  endfunction

  function automatic logic [7:0] putBit(input logic [7:0] value, input logic [2:0] pos, input logic b);
    putBit = b ? (value | bitMask(pos)) : (value & ~bitMask(pos));
  endfunction

  assign op         = bit_flag_exec_pkg::op_t'(opCode);
  // Stalling during the write half of an I/O op keeps the port single-issue
  assign issueReady = (state_reg == bit_flag_exec_pkg::stIdle);
  assign take       = issueValid && issueReady;
  assign sleepTake  = take && (op == bit_flag_exec_pkg::sleepOp);
  assign flagsOut   = flags_reg;
  assign ioReadAddr = ioAddr;

  rotate_carry_unit rotUnit (
    .dirRight (op == bit_flag_exec_pkg::rotateRightCarryOp),
    .operand  (regReadData),
    .carryIn  (flags_reg[`FLAG_C_POS]),
    .result   (rotResult),
    .carryOut (rotC),
    .zeroOut  (rotZ),
    .negOut   (rotN),
    .ovfOut   (rotV)
  );

  always_comb begin
    state_next = state_reg;
    if (take && (op == bit_flag_exec_pkg::ioBitSetOp || op == bit_flag_exec_pkg::ioBitClearOp)) begin
      state_next = bit_flag_exec_pkg::stIoBusy;
    end else if (state_reg == bit_flag_exec_pkg::stIoBusy) begin
      state_next = bit_flag_exec_pkg::stIdle;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_reg <= bit_flag_exec_pkg::stIdle;
    end else begin
      state_reg <= state_next;
    end
  end

  // Read sampled in cycle one; modify-write issued in cycle two
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ioBit_reg   <= 3'h0;
      ioWriteEn   <= 1'b0;
      ioWriteAddr <= 6'h00;
      ioWriteData <= 8'h00;
    end else begin
      ioWriteEn <= 1'b0;
      if (state_next == bit_flag_exec_pkg::stIoBusy) begin
        ioBit_reg   <= bitSel;
        ioWriteAddr <= ioAddr;
        ioWriteData <= putBit(ioReadData, bitSel, op == bit_flag_exec_pkg::ioBitSetOp);
        ioWriteEn  <= 1'b1;
      end
    end
  end

  always_comb begin
    flags_next = flags_reg;
    if (take) begin
      unique case (op)
        bit_flag_exec_pkg::rotateLeftCarryOp, bit_flag_exec_pkg::rotateRightCarryOp: begin
          flags_next[`FLAG_C_POS] = rotC;
          flags_next[`FLAG_Z_POS] = rotZ;
          flags_next[`FLAG_N_POS] = rotN;
          flags_next[`FLAG_V_POS] = rotV;
        end
        bit_flag_exec_pkg::bitToFlagOp:      flags_next[`FLAG_T_POS] = regReadData[bitSel];
        bit_flag_exec_pkg::signFlagSetOp:    flags_next[`FLAG_S_POS] = 1'b1;
        bit_flag_exec_pkg::signFlagClearOp:  flags_next[`FLAG_S_POS] = 1'b0;
        bit_flag_exec_pkg::overflowSetOp:    flags_next[`FLAG_V_POS] = 1'b1;
        bit_flag_exec_pkg::overflowClearOp:  flags_next[`FLAG_V_POS] = 1'b0;
        bit_flag_exec_pkg::halfCarrySetOp:   flags_next[`FLAG_H_POS] = 1'b1;
        bit_flag_exec_pkg::halfCarryClearOp: flags_next[`FLAG_H_POS] = 1'b0;
        default:                             flags_next = flags_reg;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      flags_reg <= `FLAGS_RESET;
    end else begin
      flags_reg <= flags_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      regWriteEn   <= 1'b0;
      regWriteData <= 8'h00;
    end else begin
      regWriteEn <= 1'b0;
      if (take && (op == bit_flag_exec_pkg::rotateLeftCarryOp || op == bit_flag_exec_pkg::rotateRightCarryOp)) begin
        regWriteEn   <= 1'b1;
        regWriteData <= rotResult;
      end else if (take && op == bit_flag_exec_pkg::flagToBitOp) begin
        regWriteEn   <= 1'b1;
        regWriteData <= putBit(regReadData, bitSel, flags_reg[`FLAG_T_POS]);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sleepReq        <= 1'b0;
      watchdogRestart <= 1'b0;
      instrDone       <= 1'b0;
    end else begin
      sleepReq        <= sleepTake;
      watchdogRestart <= take && (op == bit_flag_exec_pkg::watchdogRestartOp);
      // Single-cycle ops retire at once; I/O ops retire after the write cycle
      instrDone <= (take && state_next == bit_flag_exec_pkg::stIdle) ||
                   (state_reg == bit_flag_exec_pkg::stIoBusy);
    end
  end

  ioop_two_cycle_a: assert property (@(posedge mclk) disable iff (!resetn)
    take && (op == bit_flag_exec_pkg::ioBitSetOp) |=> ioWriteEn && ioWriteData[ioBit_reg] ##1 instrDone)
    else $error("io set did not finish in two cycles");
  ioclr_write_a: assert property (@(posedge mclk) disable iff (!resetn)
    take && (op == bit_flag_exec_pkg::ioBitClearOp) |=> !ioWriteData[ioBit_reg] && !issueReady)
    else $error("io clear bit not zero");
  rol_carry_a: assert property (@(posedge mclk) disable iff (!resetn)
    take && (op == bit_flag_exec_pkg::rotateLeftCarryOp) |=>
    flagsOut[`FLAG_C_POS] == $past(regReadData[7]) && regWriteData[0] == $past(flags_reg[`FLAG_C_POS]))
    else $error("rotate left carry wrong");
  ror_carry_a: assert property (@(posedge mclk) disable iff (!resetn)
    take && (op == bit_flag_exec_pkg::rotateRightCarryOp) |=>
    flagsOut[`FLAG_C_POS] == $past(regReadData[0]) && regWriteData[7] == $past(flags_reg[`FLAG_C_POS]))
    else $error("rotate right carry wrong");
  bst_only_t_a: assert property (@(posedge mclk) disable iff (!resetn)
    take && (op == bit_flag_exec_pkg::bitToFlagOp) |=>
    (flagsOut & 8'hbf) == ($past(flags_reg) & 8'hbf))
    else $error("bit store touched other flags");
  bld_flags_a: assert property (@(posedge mclk) disable iff (!resetn)
    take && (op == bit_flag_exec_pkg::flagToBitOp) |=> regWriteEn && $stable(flagsOut))
    else $error("bit load changed flags");
  sign_set_a: assert property (@(posedge mclk) disable iff (!resetn)
    take && (op == bit_flag_exec_pkg::signFlagSetOp) |=> flagsOut[`FLAG_S_POS])
    else $error("sign flag not set");
  sign_clear_a: assert property (@(posedge mclk) disable iff (!resetn)
    take && (op == bit_flag_exec_pkg::signFlagClearOp) |=> !flagsOut[`FLAG_S_POS])
    else $error("sign flag not cleared");
  ovf_set_a: assert property (@(posedge mclk) disable iff (!resetn)
    take && (op == bit_flag_exec_pkg::overflowSetOp) |=> flagsOut[`FLAG_V_POS])
    else $error("overflow not set");
  ovf_clear_a: assert property (@(posedge mclk) disable iff (!resetn)
    take && (op == bit_flag_exec_pkg::overflowClearOp) |=> !flagsOut[`FLAG_V_POS])
    else $error("overflow not cleared");
  half_set_a: assert property (@(posedge mclk) disable iff (!resetn)
    take && (op == bit_flag_exec_pkg::halfCarrySetOp) |=> flagsOut[`FLAG_H_POS])
    else $error("half carry not set");
  half_clear_a: assert property (@(posedge mclk) disable iff (!resetn)
    take && (op == bit_flag_exec_pkg::halfCarryClearOp) |=> !flagsOut[`FLAG_H_POS])
    else $error("half carry not cleared");
  // A second sleep taken back to back legally keeps the request high
  sleep_pulse_a: assert property (@(posedge mclk) disable iff (!resetn)
    sleepTake |=> sleepReq && $stable(flagsOut) ##1 (!sleepReq || $past(sleepTake)))
    else $error("sleep request not one pulse");
  wdr_pulse_a: assert property (@(posedge mclk) disable iff (!resetn)
    take && (op == bit_flag_exec_pkg::watchdogRestartOp) |=> watchdogRestart && instrDone)
    else $error("watchdog restart missing");
  unknown_nop_a: assert property (@(posedge mclk) disable iff (!resetn)
    take && (opCode == 4'hf || opCode == 4'h0) |=> $stable(flagsOut) && !regWriteEn && !ioWriteEn && instrDone)
    else $error("unknown opcode had effect");
endmodule
`default_nettype wire

/* bit_flag_exec_cfg.svh */
// Status flag positions, cycle counts and reset values
`ifndef BIT_FLAG_EXEC_CFG_SVH
`define BIT_FLAG_EXEC_CFG_SVH
`define FLAG_C_POS 3'h0
`define FLAG_Z_POS 3'h1
`define FLAG_N_POS 3'h2
`define FLAG_V_POS 3'h3
`define FLAG_S_POS 3'h4
`define FLAG_H_POS 3'h5
`define FLAG_T_POS 3'h6
`define FLAG_I_POS 3'h7
`define FLAGS_RESET 8'h00
`define IO_CYCLES 2'h2
`define SINGLE_CYCLES 2'h1
`endif

/* bit_flag_exec_pkg.sv */
// Types for the bit and flag execute stage
`default_nettype none
package bit_flag_exec_pkg;
  typedef enum logic [3:0] {
    opNop              = 4'h0,
    ioBitSetOp         = 4'h1,
    ioBitClearOp       = 4'h2,
    rotateLeftCarryOp  = 4'h3,
    rotateRightCarryOp = 4'h4,
    bitToFlagOp        = 4'h5,
    flagToBitOp        = 4'h6,
    signFlagSetOp      = 4'h7,
    signFlagClearOp    = 4'h8,
    overflowSetOp      = 4'h9,
    overflowClearOp    = 4'ha,
    halfCarrySetOp     = 4'hb,
    halfCarryClearOp   = 4'hc,
    sleepOp            = 4'hd,
    watchdogRestartOp  = 4'he
  } op_t;
  typedef enum logic [0:0] {
    stIdle   = 1'b0,
    stIoBusy = 1'b1
  } state_t;
endpackage
`default_nettype wire

/* rotate_carry_unit.sv */
// Rotate through carry with flag results
`timescale 1ns/1ps
`default_nettype none
module rotate_carry_unit (
  input  wire logic       dirRight,
  input  wire logic [7:0] operand,
  input  wire logic       carryIn,
  output logic      [7:0] result,
  output logic            carryOut,
  output logic            zeroOut,
  output logic            negOut,
  output logic            ovfOut
);
  always_comb begin
    if (dirRight) begin
      result   = {carryIn, operand[7:1]};
      carryOut = operand[0];
    end else begin
      result   = {operand[6:0], carryIn};
      carryOut = operand[7];
    end
    zeroOut = (result == 8'h00);
    negOut  = result[7];
    // Overflow is N xor C after any rotate
    ovfOut  = result[7] ^ carryOut;
  end
endmodule
`default_nettype wire

/* bit_and_flag_instruction_exec_tb.sv */
// Self-checking testbench for the bit and flag execute stage
`timescale 1ns/1ps
`default_nettype none
`include "bit_flag_exec_cfg.svh"
module bit_and_flag_instruction_exec_tb;
  logic       mclk = 1'b0;
  logic       resetn = 1'b0;
  logic       issueValid = 1'b0;
  logic [3:0] opCode = 4'h0;
  logic [2:0] bitSel = 3'h0;
  logic [5:0] ioAddr = 6'h00;
  logic [7:0] ioReadData = 8'h00;
  logic [7:0] regReadData = 8'h00;
  logic       issueReady;
  logic [5:0] ioWriteAddr;
  logic [7:0] ioWriteData;
  logic       ioWriteEn;
  logic [5:0] ioReadAddr;
  logic [7:0] regWriteData;
  logic       regWriteEn;
  logic [7:0] flagsOut;
  logic       sleepReq;
  logic       watchdogRestart;
  logic       instrDone;
  logic [7:0] expF = 8'h00;
  int         errCount = 0;
  int         totalChecks = 0;
  logic [7:0] rotVals [6] = '{8'h80, 8'h00, 8'h01, 8'h00, 8'hc3, 8'h3c};

  bit_and_flag_instruction_exec u_dut (.mclk(mclk), .resetn(resetn), .issueValid(issueValid), .opCode(opCode),
    .bitSel(bitSel), .ioAddr(ioAddr), .ioReadData(ioReadData), .regReadData(regReadData), .issueReady(issueReady),
    .ioWriteAddr(ioWriteAddr), .ioWriteData(ioWriteData), .ioWriteEn(ioWriteEn), .ioReadAddr(ioReadAddr),
    .regWriteData(regWriteData), .regWriteEn(regWriteEn), .flagsOut(flagsOut), .sleepReq(sleepReq),
    .watchdogRestart(watchdogRestart), .instrDone(instrDone));

  always #4 mclk = ~mclk;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      errCount++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic check1(input logic seen, input logic exp);
    check({7'h00, seen}, {7'h00, exp});
  endtask

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Issues one single-cycle op; valid is left high so the next call follows back to back
  task automatic exec1(input logic [3:0] op, input logic [2:0] b, input logic [7:0] r);
    logic [7:0] res;
    logic       we;
    res = r;
    we = 1'b0;
    case (op)
      bit_flag_exec_pkg::rotateLeftCarryOp: begin
        res = {r[6:0], expF[`FLAG_C_POS]};
        expF[`FLAG_C_POS] = r[7];
      end
      bit_flag_exec_pkg::rotateRightCarryOp: begin
        res = {expF[`FLAG_C_POS], r[7:1]};
        expF[`FLAG_C_POS] = r[0];
      end
      bit_flag_exec_pkg::bitToFlagOp: expF[`FLAG_T_POS] = r[b];
      bit_flag_exec_pkg::flagToBitOp: begin
        res[b] = expF[`FLAG_T_POS];
        we = 1'b1;
      end
      bit_flag_exec_pkg::signFlagSetOp: expF[`FLAG_S_POS] = 1'b1;
      bit_flag_exec_pkg::signFlagClearOp: expF[`FLAG_S_POS] = 1'b0;
      bit_flag_exec_pkg::overflowSetOp: expF[`FLAG_V_POS] = 1'b1;
      bit_flag_exec_pkg::overflowClearOp: expF[`FLAG_V_POS] = 1'b0;
      bit_flag_exec_pkg::halfCarrySetOp: expF[`FLAG_H_POS] = 1'b1;
      bit_flag_exec_pkg::halfCarryClearOp: expF[`FLAG_H_POS] = 1'b0;
      default: ;
    endcase
    if (op == bit_flag_exec_pkg::rotateLeftCarryOp || op == bit_flag_exec_pkg::rotateRightCarryOp) begin
      we = 1'b1;
      expF[`FLAG_Z_POS] = (res == 8'h00);
      expF[`FLAG_N_POS] = res[7];
      expF[`FLAG_V_POS] = res[7] ^ expF[`FLAG_C_POS];
    end
    opCode = op;
    bitSel = b;
    regReadData = r;
    issueValid = 1'b1;
    @(posedge mclk);
    #1;
    check(flagsOut, expF);
    check1(regWriteEn, we);
    if (we)
      check(regWriteData, res);
    check1(instrDone, 1'b1);
    check1(issueReady, 1'b1);
    check1(ioWriteEn, 1'b0);
    check1(sleepReq, op == bit_flag_exec_pkg::sleepOp);
    check1(watchdogRestart, op == bit_flag_exec_pkg::watchdogRestartOp);
  endtask

  // I/O bit op, then an issue in the bubble cycle that must be ignored
  task automatic ioOp(input logic setIt, input logic [2:0] b, input logic [5:0] a, input logic [7:0] d);
    logic [7:0] mask;
    mask = 8'h01 << b;
    opCode = setIt ? bit_flag_exec_pkg::ioBitSetOp : bit_flag_exec_pkg::ioBitClearOp;
    bitSel = b;
    ioAddr = a;
    ioReadData = d;
    issueValid = 1'b1;
    @(posedge mclk);
    #1;
    check({2'b00, ioReadAddr}, {2'b00, a});
    check1(ioWriteEn, 1'b1);
    check({2'b00, ioWriteAddr}, {2'b00, a});
    check(ioWriteData, setIt ? (d | mask) : (d & ~mask));
    check1(instrDone, 1'b0);
    check1(issueReady, 1'b0);
    opCode = bit_flag_exec_pkg::signFlagSetOp;
    @(posedge mclk);
    #1;
    check1(instrDone, 1'b1);
    check1(ioWriteEn, 1'b0);
    check(flagsOut, expF);
  endtask

  task automatic endTest(input string name);
    issueValid = 1'b0;
    @(posedge mclk);
    #1;
    $display("Test %s finished", name);
  endtask

  initial begin
    repeat (5000) @(posedge mclk);
    errCount++;
    summarize();
  end

  initial begin
    repeat (2) @(posedge mclk);
    #1;
    check(flagsOut, `FLAGS_RESET);
    check1(issueReady, 1'b1);
    resetn = 1'b1;
    endTest("reset");
    for (int i = 0; i < 8; i++) begin
      ioOp(1'b1, 3'(i), 6'(6'h3f - i), 8'h5a);
      ioOp(1'b0, 3'(i), 6'(i), 8'h5a);
    end
    endTest("io bits");
    for (int i = 0; i < 6; i++)
      exec1(i[0] ? bit_flag_exec_pkg::rotateRightCarryOp : bit_flag_exec_pkg::rotateLeftCarryOp, 3'h0, rotVals[i]);
    endTest("rotate");
    exec1(bit_flag_exec_pkg::bitToFlagOp, 3'h5, 8'h20);
    exec1(bit_flag_exec_pkg::flagToBitOp, 3'h0, 8'hf0);
    exec1(bit_flag_exec_pkg::bitToFlagOp, 3'h7, 8'h7f);
    exec1(bit_flag_exec_pkg::flagToBitOp, 3'h6, 8'hff);
    endTest("transfer flag");
    for (int k = 7; k <= 12; k++)
      exec1(4'(k), 3'h0, 8'h00);
    exec1(bit_flag_exec_pkg::overflowSetOp, 3'h0, 8'h00);
    exec1(bit_flag_exec_pkg::halfCarrySetOp, 3'h0, 8'h00);
    endTest("flag ops");
    exec1(bit_flag_exec_pkg::sleepOp, 3'h0, 8'h00);
    exec1(bit_flag_exec_pkg::watchdogRestartOp, 3'h0, 8'h00);
    exec1(4'h0, 3'h0, 8'h00);
    exec1(4'hf, 3'h0, 8'h00);
    exec1(4'h0, 3'h0, 8'h00);
    endTest("control and nop");
    // Reset in mid-run must clear flags left set above
    resetn = 1'b0;
    @(posedge mclk);
    #1;
    expF = `FLAGS_RESET;
    check(flagsOut, expF);
    check1(issueReady, 1'b1);
    resetn = 1'b1;
    exec1(bit_flag_exec_pkg::signFlagSetOp, 3'h0, 8'h00);
    endTest("second reset");
    summarize();
  end
endmodule
`default_nettype wire
